// File: design/phase_gen.v
// Purpose: four-phase divider making instruction-cycle strobes
// Assumes: ref_clk is the oscillator, four periods per instruction cycle
// Notes: phases run in sleep so the edge sampler stays defined
`include "timer_counter_map.vh"
module phase_gen (
    input wire ref_clk,
    input wire arst_n,
    output wire q2Strobe,
    output wire q4Strobe
);
    reg [1:0] phase;

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            phase <= 2'h0;
        end else begin
            phase <= phase + 2'h1;
        end
    end

    assign q2Strobe = (phase == 2'h1);
    assign q4Strobe = (phase == 2'h3);
endmodule // phase_gen

// File: design/ripple_prescaler.v
// Purpose: eight-stage divider with symmetric outputs, one per ratio
// Assumes: input already synchronous to ref_clk
// Notes: modelled as a toggle chain clocked by ref_clk enables
`include "timer_counter_map.vh"
module ripple_prescaler #(
    parameter STAGES = 8
) (
    input wire ref_clk,
    input wire arst_n,
    input wire clear,
    input wire tickIn,
    output wire [STAGES-1:0] taps
);
    reg [STAGES-1:0] stage;
    wire [STAGES:0] carry;

    assign carry[0] = tickIn;
    genvar i;
    generate
        for (i = 0; i < STAGES; i = i + 1) begin : g_stage
            // each stage halves its input with equal high and low halves
            always @(posedge ref_clk or negedge arst_n) begin
                if (!arst_n) begin
                    stage[i] <= 1'b0;
                end else if (clear) begin
                    stage[i] <= 1'b0;
                end else if (carry[i]) begin
                    stage[i] <= ~stage[i];
                end
            end
            assign carry[i+1] = carry[i] & stage[i];
        end
    endgenerate

    assign taps = stage;
endmodule // ripple_prescaler

// File: design/timer_counter.v
// Purpose: 8-bit timer/counter with shared prescaler and overflow flag
// Assumes: software port strobes are one cycle, synchronous to ref_clk
// Notes: ref_clk is the oscillator; an instruction cycle is four periods
//
// How it works
// - source select clear counts instruction cycles
// - write holds counting two instruction cycles
// - source select set counts pin edges
// - edge select clear rising, set falling
// - one prescaler, counter or watchdog
// - ratios two to two hundred fifty-six
// - prescaler count never readable or writable
// - count register readable and writable anytime
// - wrap from ff to 00 sets flag
// - request only while enable bit set
// - sleep stops counter, no overflow
// - prescaler output sampled on q2, q4
// - prescaler is symmetric ripple divider
// - increment follows synchronisation stage, except unscaled instruction-cycle count
// - count write clears prescaler if assigned
// - low option nibble sets assignment, ratio
//
// The implementer's own choices: the strobed register port and the address map.
`include "timer_counter_map.vh"
module timer_counter #(
    parameter WIDTH = 8,
    parameter PRESCALE_STAGES = 8
) (
    input wire ref_clk,
    input wire arst_n,
    input wire [1:0] addr,
    input wire [7:0] wrData,
    input wire wrStrobe,
    input wire rdStrobe,
    output reg [7:0] rdData,
    input wire countClockPin,
    input wire sleep,
    input wire watchdogTick,
    input wire watchdogClear,
    output wire watchdogScaled,
    output wire overflowIrq
);
    wire q2Strobe;
    wire q4Strobe;
    reg [WIDTH-1:0] count;
    reg [7:0] option;
    reg overflowFlag;
    reg overflowIrqEnable;
    reg [1:0] holdCount;
    reg pinPrev;
    reg sampled;
    reg sampledPrev;
    wire clockSource = option[`OPT_CLOCK_SOURCE];
    wire edgeSelect = option[`OPT_EDGE_SELECT];
    wire prescalerAssign = option[`OPT_PRESCALER_ASSIGN];
    wire [2:0] ratioField = option[`OPT_RATIO_HI:`OPT_RATIO_LO];
    wire wrCount = wrStrobe && (addr == `ADDR_COUNT);
    wire wrOption = wrStrobe && (addr == `ADDR_OPTION);
    wire wrIntCtrl = wrStrobe && (addr == `ADDR_INTCTRL);

    phase_gen u_phase (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .q2Strobe(q2Strobe),
        .q4Strobe(q4Strobe)
    );

    wire pinLevel = countClockPin ^ edgeSelect;
    // pin taken as synchronous; edge seen as a rise of pinLevel
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pinPrev <= 1'b0;
        end else begin
            pinPrev <= pinLevel;
        end
    end
    wire pinEdge = pinLevel & ~pinPrev;

    wire sourceTick = clockSource ? pinEdge : q4Strobe;

    // prescaler goes to one owner only
    wire toCounter = ~prescalerAssign;
    wire [PRESCALE_STAGES-1:0] taps;
    wire prescaleClear = (toCounter && wrCount) ||
        (prescalerAssign && watchdogClear);
    wire prescaleIn = (toCounter ? sourceTick : watchdogTick) & ~sleep;

    // prescaler count has no port path
    ripple_prescaler #(
        .STAGES(PRESCALE_STAGES)
    ) u_prescaler (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .clear(prescaleClear),
        .tickIn(prescaleIn),
        .taps(taps)
    );

    // ratio from two to two fifty-six
    // ratio n takes stage n, divide by 2^(n+1)
    wire scaledLevel = taps[ratioField];
    assign watchdogScaled = prescalerAssign ? scaledLevel : watchdogTick;

    // unscaled path when watchdog owns prescaler
    // level sampled on q2 and q4, used in every path except the unscaled instruction-cycle count
    wire preLevel = toCounter ? scaledLevel :
        (clockSource ? pinLevel : q4Strobe);
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sampled <= 1'b0;
            sampledPrev <= 1'b0;
        end else if (q2Strobe || q4Strobe) begin
            sampled <= preLevel;
            sampledPrev <= sampled;
        end
    end

    // increment only after synchronised rise, or on q4Strobe when counting unscaled instruction cycles
    // a rise caught at q4 shows at q2, so both sample edges may tick
    wire syncedTick = (q2Strobe || q4Strobe) && sampled && !sampledPrev;
    wire timerTick = (!clockSource && !toCounter) ? q4Strobe : syncedTick;

    wire incEnable = timerTick && !sleep && (holdCount == 2'h0);

    // two instruction cycle hold after write
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            holdCount <= 2'h0;
        end else if (wrCount) begin
            holdCount <= `WRITE_HOLD_CYCLES;
        end else if (q4Strobe && holdCount != 2'h0) begin
            holdCount <= holdCount - 2'h1;
        end
    end

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            count <= `COUNT_RESET;
        end else if (wrCount) begin
            count <= wrData[WIDTH-1:0];
        end else if (incEnable) begin
            count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    wire wrap = incEnable && (&count);

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            option <= `OPTION_RESET;
            overflowFlag <= 1'b0;
            overflowIrqEnable <= 1'b0;
        end else begin
            if (wrOption) begin
                option <= wrData;
            end
            if (wrIntCtrl) begin
                overflowIrqEnable <= wrData[`INT_IRQ_ENABLE];
            end
            // set wins over a clear in the same cycle
            if (wrap) begin
                overflowFlag <= 1'b1;
            end else if (wrIntCtrl) begin
                overflowFlag <= wrData[`INT_OVERFLOW_FLAG];
            end
        end
    end

    assign overflowIrq = overflowFlag & overflowIrqEnable;

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdData <= 8'h00;
        end else if (rdStrobe) begin
            case (addr)
                `ADDR_COUNT: rdData <= count;
                `ADDR_OPTION: rdData <= option;
                `ADDR_INTCTRL: rdData <= {2'h0, overflowIrqEnable, 2'h0,
                    overflowFlag, 2'h0};
                default: rdData <= 8'h00;
            endcase
        end else begin
            rdData <= 8'h00;
        end
    end
endmodule // timer_counter

// File: design/timer_counter_map.vh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: one 8-bit data register per address on the plain port
// Notes: offsets are local to this block
`ifndef TIMER_COUNTER_MAP_VH
`define TIMER_COUNTER_MAP_VH

`define ADDR_COUNT 2'h0
`define ADDR_OPTION 2'h1
`define ADDR_INTCTRL 2'h2

`define OPT_CLOCK_SOURCE 5
`define OPT_EDGE_SELECT 4
`define OPT_PRESCALER_ASSIGN 3
`define OPT_RATIO_HI 2
`define OPT_RATIO_LO 0

`define INT_IRQ_ENABLE 5
`define INT_OVERFLOW_FLAG 2

`define OPTION_RESET 8'hff
`define INTCTRL_RESET 8'h00
`define COUNT_RESET 8'h00

`define OSC_PER_INSTR 4
`define WRITE_HOLD_CYCLES 2'h2

`endif

// File: verif/count_pin_source.sv
// Purpose: external clock source on the count pin
// Assumes: called from the bench right after a rising edge
// Notes: idles low; each level lasts eight clocks
module count_pin_source (
    input wire ref_clk,
    output logic countClockPin
);
    timeunit 1ns;
    timeprecision 1ns;
    initial countClockPin = 1'b0;
    task automatic level(input logic lv);
        countClockPin <= lv;
        repeat (8) @(posedge ref_clk);
    endtask
    task automatic pulses(input int n);
        repeat (n) begin
            level(1'b1);
            level(1'b0);
        end
    endtask
endmodule // count_pin_source

// File: verif/tb_timer_counter.sv
// Purpose: self-checking bench for the timer/counter
// Assumes: q4 every fourth clock, phase unknown to the bench
// Notes: waits skip the two held q4 after a count write
module tb_timer_counter;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0, arst_n = 1'b0, sleep = 1'b0;
    logic wrStrobe = 1'b0, rdStrobe = 1'b0;
    logic wdTick = 1'b0, wdClear = 1'b0;
    wire wdScaled;
    logic [1:0] addr = 2'h0;
    logic [7:0] wrData = 8'h00, v;
    wire [7:0] rdData;
    wire pin, overflowIrq;
    int nErrors = 0, nCompared = 0;
    always #25 ref_clk = ~ref_clk;
    timer_counter dut (.ref_clk(ref_clk), .arst_n(arst_n), .addr(addr),
        .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
        .rdData(rdData), .countClockPin(pin), .sleep(sleep),
        .watchdogTick(wdTick), .watchdogClear(wdClear),
        .watchdogScaled(wdScaled), .overflowIrq(overflowIrq));
    count_pin_source src (.ref_clk(ref_clk), .countClockPin(pin));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        nCompared++;
        if (seen !== exp) begin
            nErrors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        addr <= a;
        wrData <= d;
        wrStrobe <= 1'b1;
        @(posedge ref_clk);
        wrStrobe <= 1'b0;
    endtask
    // back-to-back writes keep the strobe high between them
    task automatic wr2(input logic [1:0] a, input logic [7:0] d,
        input logic [1:0] b, input logic [7:0] e);
        addr <= a;
        wrData <= d;
        wrStrobe <= 1'b1;
        @(posedge ref_clk);
        addr <= b;
        wrData <= e;
        @(posedge ref_clk);
        wrStrobe <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        addr <= a;
        rdStrobe <= 1'b1;
        @(posedge ref_clk);
        rdStrobe <= 1'b0;
        #1 d = rdData;
        @(posedge ref_clk);
    endtask
    task automatic irq(input logic e);
        #1 check(8'(overflowIrq), 8'(e));
        @(posedge ref_clk);
    endtask
    task automatic regs();
        rd(2'h1, v);
        check(v, 8'hff);
        wr(2'h3, 8'h5a);
        rd(2'h3, v);
        check(v, 8'h00);
    endtask
    task automatic wdog();
        wr(2'h1, 8'h08);
        wdTick <= 1'b1;
        @(posedge ref_clk);
        wdTick <= 1'b0;
        @(posedge ref_clk);
        #1 check(8'(wdScaled), 8'h01);
        wdClear <= 1'b1;
        @(posedge ref_clk);
        wdClear <= 1'b0;
        @(posedge ref_clk);
        #1 check(8'(wdScaled), 8'h00);
        wr(2'h1, 8'h00);
        wdTick <= 1'b1;
        #1 check(8'(wdScaled), 8'h01);
        @(posedge ref_clk);
        wdTick <= 1'b0;
        #1 check(8'(wdScaled), 8'h00);
        @(posedge ref_clk);
    endtask
    task automatic timer();
        wr(2'h1, 8'h08);
        rd(2'h1, v);
        check(v, 8'h08);
        wr(2'h0, 8'hfe);
        rd(2'h0, v);
        check(v, 8'hfe);
        // 17 edges hold 4 or 5 q4, two of them held
        repeat (15) @(posedge ref_clk);
        rd(2'h0, v);
        check(8'(v inside {8'h00, 8'h01}), 8'h01);
        rd(2'h2, v);
        check(v, 8'h04);
        irq(1'b0);
        wr(2'h2, 8'h24);
        rd(2'h2, v);
        check(v, 8'h24);
        irq(1'b1);
        wr(2'h2, 8'h20);
        irq(1'b0);
        sleep <= 1'b1;
        wr2(2'h2, 8'h00, 2'h0, 8'h10);
        repeat (40) @(posedge ref_clk);
        rd(2'h0, v);
        check(v, 8'h10);
        sleep <= 1'b0;
    endtask
    task automatic edges();
        for (int e = 0; e < 2; e++) begin
            wr2(2'h1, {3'h1, e[0], 4'h8}, 2'h0, 8'h00);
            repeat (12) @(posedge ref_clk);
            src.level(1'b1);
            rd(2'h0, v);
            check(v, 8'(!e[0]));
            src.level(1'b0);
            rd(2'h0, v);
            check(v, 8'h01);
        end
    endtask
    task automatic scaled();
        for (int n = 0; n < 4; n++) begin
            wr2(2'h1, {5'h04, n[2:0]}, 2'h0, 8'h00);
            repeat (12) @(posedge ref_clk);
            src.pulses(16);
            rd(2'h0, v);
            check(v, 8'(16 >> (n + 1)));
        end
        wr(2'h1, 8'h20);
        src.pulses(1);
        wr(2'h0, 8'h00);
        repeat (12) @(posedge ref_clk);
        src.pulses(1);
        rd(2'h0, v);
        check(v, 8'h01);
    endtask
    task automatic finish_test();
        $display("compared %0d errors %0d", nCompared, nErrors);
        if (nErrors == 0 && nCompared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk);
        nErrors++;
        finish_test();
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        arst_n <= 1'b1;
        regs();
        wdog();
        timer();
        edges();
        scaled();
        finish_test();
    end
endmodule // tb_timer_counter

// File: verif/timer_counter_chk.sv
// Purpose: port checks of the timer/counter
// Assumes: one-cycle strobes, read data one cycle later
// Notes: count is hidden, so checks ride on read-backs
module timer_counter_chk (
    input wire ref_clk,
    input wire arst_n,
    input wire [1:0] addr,
    input wire [7:0] wrData,
    input wire wrStrobe,
    input wire rdStrobe,
    input wire [7:0] rdData,
    input wire sleep,
    input wire overflowIrq
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    sequence wrRd(a);
        wrStrobe && addr == a ##1 rdStrobe && addr == a;
    endsequence
    chk_rd_idle: assert property (!rdStrobe |=> rdData == 8'h00)
        else $error("read data not zero");
    chk_unmapped_zero: assert property
        (rdStrobe && addr == 2'h3 |=> rdData == 8'h00) else $error("unmapped");
    chk_count_back: assert property
        (wrRd(2'h0) |=> rdData == $past(wrData, 2)) else $error("count moved");
    chk_option_back: assert property
        (wrRd(2'h1) |=> rdData == $past(wrData, 2)) else $error("option");
    chk_enable_back: assert property
        (wrRd(2'h2) |=> rdData[5] == $past(wrData[5], 2)) else $error("enable");
    chk_irq_masked: assert property
        (wrStrobe && addr == 2'h2 && !wrData[5] |=> !overflowIrq)
        else $error("request not masked");
    chk_irq_fall: assert property
        ($fell(overflowIrq) |-> $past(wrStrobe && addr == 2'h2))
        else $error("request dropped alone");
    chk_sleep_quiet: assert property
        ($rose(overflowIrq) |-> $past(wrStrobe) || !$past(sleep))
        else $error("overflow in sleep");
endmodule // timer_counter_chk
bind timer_counter timer_counter_chk chk (.ref_clk(ref_clk),
    .arst_n(arst_n), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe),
    .rdStrobe(rdStrobe), .rdData(rdData), .sleep(sleep),
    .overflowIrq(overflowIrq));
